// ### core/epc_quad_step.v
`timescale 1ns/10ps
`include "epc_map.vh"
// ----------------------------------------
// per-edge count step for all decode modes
// ----------------------------------------
module epc_quad_step
(
  // decode mode
  input  wire [1:0] mode,
  // synchronised levels and edges
  input  wire       a_lvl,
  input  wire       b_lvl,
  input  wire       a_rise,
  input  wire       a_fall,
  input  wire       b_rise,
  input  wire       b_fall,
  // step request
  output reg        inc,
  output reg        dec
);

  // a leads b when a moves to differ from b, or b moves to match a
  wire a_edge;
  wire b_edge;
  wire a_dir_up;
  wire b_dir_up;

  assign a_edge   = a_rise | a_fall;
  assign b_edge   = b_rise | b_fall;
  assign a_dir_up = (a_lvl != b_lvl);
  assign b_dir_up = (a_lvl == b_lvl);

  always @*
  begin
    inc = 1'b0;
    dec = 1'b0;
    case (mode)
      `EPC_MODE_SINGLE_EDGE_DECODE:
      begin
        inc = a_rise & ~b_lvl;
        dec = a_fall & ~b_lvl;
      end
      `EPC_MODE_DOUBLE_EDGE_DECODE:
      begin
        inc = a_edge & a_dir_up;
        dec = a_edge & ~a_dir_up;
      end
      `EPC_MODE_QUAD_EDGE_DECODE:
      begin
        // simultaneous a and b edges are illegal quadrature: dropped
        inc = (a_edge & ~b_edge & a_dir_up) |
              (b_edge & ~a_edge & b_dir_up);
        dec = (a_edge & ~b_edge & ~a_dir_up) |
              (b_edge & ~a_edge & ~b_dir_up);
      end
      `EPC_MODE_TWO:
      begin
        // both rising together cancel out
        inc = a_rise & ~b_rise;
        dec = b_rise & ~a_rise;
      end
      default:
      begin
        inc = 1'b0;
        dec = 1'b0;
      end
    endcase
  end

endmodule

// ### core/epc_sync_edge.v
`timescale 1ns/10ps
// ----------------------------------------
// two-flop synchroniser with edge detect
// ----------------------------------------
module epc_sync_edge
(
  // clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // pin side
  input  wire pin_in,
  // synchronised side
  output reg  level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg prev_reg;

  // first flop feeds only the second
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= 1'b0;
      level    <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_in;
      level    <= meta_reg;
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule

// ### core/epc_top.v
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "epc_map.vh"
module epc_top
#(
  parameter CNT_W = 32
)
(
  // clock and reset
  input  wire             ref_clk,
  input  wire             arst_n,
  // encoder pins
  input  wire             enc_a,
  input  wire             enc_b,
  input  wire             enc_z,
  input  wire             sample_clk,
  // axi4-lite write address
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // axi4-lite read address
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // sample strobe to the transfer engine
  output reg              sample_valid
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire a_lvl;
  wire a_rise;
  wire a_fall;
  wire b_lvl;
  wire b_rise;
  wire b_fall;
  wire z_lvl;
  wire sc_rise;
  wire sc_fall;

  epc_sync_edge u_sync_a
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (enc_a),
    .level   (a_lvl),
    .rise    (a_rise),
    .fall    (a_fall)
  );

  epc_sync_edge u_sync_b
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (enc_b),
    .level   (b_lvl),
    .rise    (b_rise),
    .fall    (b_fall)
  );

  epc_sync_edge u_sync_z
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (enc_z),
    .level   (z_lvl),
    .rise    (),
    .fall    ()
  );

  epc_sync_edge u_sync_sc
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  (sample_clk),
    .level   (),
    .rise    (sc_rise),
    .fall    (sc_fall)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]       ctrl_reg;
  reg  [CNT_W-1:0] reload_reg;
  reg  [CNT_W-1:0] pos_reg;
  reg  [CNT_W-1:0] save_reg;
  reg              svalid_reg;
  reg              ovr_reg;
  reg              armed_reg;
  reg              rearm_reg;

  wire [1:0] mode;
  wire [1:0] phase_sel;
  wire       zen;
  wire       buf_en;
  wire       sc_pol;

  assign mode      = ctrl_reg[`EPC_CTRL_MODE_HI:`EPC_CTRL_MODE_LO];
  assign phase_sel = ctrl_reg[`EPC_CTRL_PH_HI:`EPC_CTRL_PH_LO];
  assign zen       = ctrl_reg[`EPC_CTRL_ZEN];
  assign buf_en    = ctrl_reg[`EPC_CTRL_BUF];
  assign sc_pol    = ctrl_reg[`EPC_CTRL_SCPOL];

  // ----------------------------------------
  // count decision
  // ----------------------------------------
  wire inc;
  wire dec;

  epc_quad_step u_step
  (
    .mode   (mode),
    .a_lvl  (a_lvl),
    .b_lvl  (b_lvl),
    .a_rise (a_rise),
    .a_fall (a_fall),
    .b_rise (b_rise),
    .b_fall (b_fall),
    .inc    (inc),
    .dec    (dec)
  );

  // phase code is {b,a}; index only meaningful in quadrature modes
  wire in_phase;
  wire do_reload;
  wire sc_edge;

  assign in_phase  = ({b_lvl, a_lvl} == phase_sel);
  assign do_reload = armed_reg & zen & z_lvl & in_phase &
                     (mode != `EPC_MODE_TWO);
  assign sc_edge   = sc_pol ? sc_fall : sc_rise;

  // ----------------------------------------
  // position counter
  // ----------------------------------------
  reg [CNT_W-1:0] pos_next;

  always @*
  begin
    pos_next = pos_reg;
    if (armed_reg)
    begin
      if (inc)
        pos_next = pos_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      else if (dec)
        pos_next = pos_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // the step lands this cycle; a reload seen in the same cycle is
  // applied on the next one, after the step, within one clock
  reg reload_pend_reg;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_reg         <= {CNT_W{1'b0}};
      reload_pend_reg <= 1'b0;
    end
    else if (rearm_reg)
    begin
      pos_reg         <= {CNT_W{1'b0}};
      reload_pend_reg <= 1'b0;
    end
    else if (reload_pend_reg)
    begin
      pos_reg         <= reload_reg;
      reload_pend_reg <= 1'b0;
    end
    else
    begin
      pos_reg         <= pos_next;
      reload_pend_reg <= do_reload & (inc | dec);
      if (do_reload & ~inc & ~dec)
        pos_reg <= reload_reg;
    end
  end

  // ----------------------------------------
  // buffered capture
  // ----------------------------------------
  wire clr_save;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      save_reg     <= {CNT_W{1'b0}};
      svalid_reg   <= 1'b0;
      ovr_reg      <= 1'b0;
      sample_valid <= 1'b0;
    end
    else
    begin
      sample_valid <= 1'b0;
      if (armed_reg & buf_en & sc_edge)
      begin
        save_reg     <= pos_reg;
        sample_valid <= 1'b1;
        svalid_reg   <= 1'b1;
        if (svalid_reg & ~clr_save)
          ovr_reg <= 1'b1;
      end
      else if (clr_save)
      begin
        svalid_reg <= 1'b0;
        ovr_reg    <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write
  // ----------------------------------------
  reg  [11:0] aw_addr_reg;
  reg         aw_have_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_have_reg;
  wire        wr_go;

  assign wr_go = aw_have_reg & w_have_reg & ~s_axi_bvalid;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPC_RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= `EPC_CTRL_RST;
      reload_reg    <= {CNT_W{1'b0}};
      armed_reg     <= 1'b0;
      rearm_reg     <= 1'b0;
    end
    else
    begin
      rearm_reg <= 1'b0;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `EPC_RESP_OKAY;
        case (aw_addr_reg)
          `EPC_OFF_CTRL:
          begin
            if (w_strb_reg[0])
            begin
              ctrl_reg  <= w_data_reg[7:0];
              // a fresh arm clears the count
              rearm_reg <= w_data_reg[`EPC_CTRL_ARM] & ~armed_reg;
              armed_reg <= w_data_reg[`EPC_CTRL_ARM];
            end
          end
          `EPC_OFF_RELOAD:
          begin
            if (w_strb_reg[0]) reload_reg[7:0]   <= w_data_reg[7:0];
            if (w_strb_reg[1]) reload_reg[15:8]  <= w_data_reg[15:8];
            if (w_strb_reg[2]) reload_reg[23:16] <= w_data_reg[23:16];
            if (w_strb_reg[3]) reload_reg[31:24] <= w_data_reg[31:24];
          end
          `EPC_OFF_POS,
          `EPC_OFF_SAVE,
          `EPC_OFF_STATUS:
            s_axi_bresp <= `EPC_RESP_OKAY;
          default:
            s_axi_bresp <= `EPC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read
  // ----------------------------------------
  // reading the save register consumes the queued sample
  assign clr_save = s_axi_arvalid & s_axi_arready &
                    (s_axi_araddr == `EPC_OFF_SAVE);

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `EPC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `EPC_RESP_OKAY;
        case (s_axi_araddr)
          `EPC_OFF_CTRL:
            s_axi_rdata <= {24'h00_0000, ctrl_reg};
          `EPC_OFF_RELOAD:
            s_axi_rdata <= reload_reg;
          `EPC_OFF_POS:
            s_axi_rdata <= pos_reg;
          `EPC_OFF_SAVE:
            s_axi_rdata <= save_reg;
          `EPC_OFF_STATUS:
            s_axi_rdata <= {26'h000_0000, z_lvl, b_lvl, a_lvl,
                            ovr_reg, svalid_reg, armed_reg};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EPC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ### dv/epc_enc_model.sv
`timescale 1ns/10ps
// ----
// encoder and sample pin model
// ----
module epc_enc_model
(
  // clock
  input wire ref_clk,
  // encoder pins
  output reg enc_a,
  output reg enc_b,
  output reg enc_z,
  output reg sample_clk
);
  initial
  begin
    {enc_a, enc_b, enc_z, sample_clk} = 4'h0;
  end
  // each level stands four clocks, twice the decoder minimum
  task put(input [3:0] v);
    @(posedge ref_clk);
    {enc_a, enc_b, enc_z, sample_clk} <= v;
    repeat (3) @(posedge ref_clk);
  endtask
  // one quadrature cycle; index high only in phase ph, 4 means never;
  // the sample pin keeps its level so a capture can straddle a cycle
  task cyc(input fwd, input [2:0] ph);
    reg [7:0] t;
    integer   i;
    t = fwd ? 8'h2d : 8'h1e;
    for (i = 0; i < 4; i = i + 1)
      put({t[2*i], t[2*i+1], ph == {1'b0, t[2*i+1], t[2*i]},
           sample_clk});
  endtask
  // two-pulse: a rise counts up, b rise counts down
  task pls(input dn);
    put({!dn, dn, 2'h0});
    put(4'h0);
  endtask
  task smp;
    put({enc_a, enc_b, enc_z, 1'b1});
    put({enc_a, enc_b, enc_z, 1'b0});
  endtask
endmodule

// ### dv/epc_top_properties.sv
`timescale 1ns/10ps
`include "epc_map.vh"
// ----
// port checker
// ----
module epc_chk
(
  // clock and reset
  input wire        ref_clk,
  input wire        arst_n,
  // pins and bus
  input wire        sample_clk,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        sample_valid
);
  // age of the last sample pin move; saturates so idle time cannot wrap
  reg       sc_q;
  reg [3:0] sc_age;
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sc_q   <= 1'b0;
      sc_age <= 4'hf;
    end
    else
    begin
      sc_q   <= sample_clk;
      sc_age <= (sample_clk != sc_q) ? 4'h0 :
                (sc_age == 4'hf) ? sc_age : sc_age + 4'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  b_hold_a: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  b_block_a: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  b_time_a: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
     |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  r_time_a: assert property
    (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  err_zero_a: assert property
    (s_axi_rvalid && s_axi_rresp == `EPC_RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
  sv_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("sample strobe too long");
  sv_cause_a: assert property (sample_valid |-> sc_age <= 4'h6)
    else $error("sample strobe without pin edge");
  cover property (s_axi_rvalid && s_axi_rresp == `EPC_RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (sample_valid);
endmodule

bind epc_top epc_chk u_chk
(
  .ref_clk, .arst_n, .sample_clk, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .sample_valid
);

// ### dv/tb_epc_top.sv
`timescale 1ns/10ps
`include "epc_map.vh"
module tb_epc_top;
  // ----
  // stimulus and model state
  // ----
  reg         ref_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg  [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, sample_valid, enc_a, enc_b, enc_z, sample_clk;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     mismatches = 0, total_checks = 0, sv_seen = 0;
  integer     m, p, nf, nb, ex, rv;
  integer     q[$];
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (sample_valid === 1'b1)
      sv_seen <= sv_seen + 1;
  epc_top DUT
  (
    .ref_clk, .arst_n, .enc_a, .enc_b, .enc_z, .sample_clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sample_valid
  );
  epc_enc_model enc (.ref_clk, .enc_a, .enc_b, .enc_z, .sample_clk);
  // ----
  // tasks
  // ----
  task wrap_up;
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task lim(input integer n);
    if (n >= 50)
    begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  endtask
  task axw(input [11:0] a, input [31:0] d, input [1:0] er = 2'h0);
    integer n;
    reg     done;
    n = 0;
    done = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!done && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    lim(done ? 0 : n);
  endtask
  task axr(input [11:0] a, input [31:0] e, input [1:0] er = 2'h0);
    integer n;
    reg     done;
    n = 0;
    done = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done && n < 50)
    begin
      @(posedge ref_clk);
      n = n + 1;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    lim(done ? 0 : n);
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    rv = $urandom(49173);
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    axr(`EPC_OFF_CTRL, 32'h0);
    axr(`EPC_OFF_STATUS, 32'h0);
    axr(12'h020, 32'h0, `EPC_RESP_SLVERR);
    axw(12'h020, 32'h1, `EPC_RESP_SLVERR);
    enc.cyc(1, 3'h4);
    enc.pls(0);
    repeat (5) @(posedge ref_clk);
    axr(`EPC_OFF_POS, 32'h0);
    for (m = 0; m < 3; m = m + 1)
    begin
      nf = $urandom_range(4, 1);
      nb = $urandom_range(3, 0);
      axw(`EPC_OFF_CTRL, 32'h0);
      axw(`EPC_OFF_CTRL, (m << 1) | 1);
      repeat (nf) enc.cyc(1, 3'h4);
      repeat (nb) enc.cyc(0, 3'h4);
      repeat (5) @(posedge ref_clk);
      axw(`EPC_OFF_POS, $urandom);
      axr(`EPC_OFF_POS, (nf - nb) << m);
    end
    axw(`EPC_OFF_CTRL, 32'h0);
    axw(`EPC_OFF_CTRL, 32'h7);
    repeat (nf) enc.pls(0);
    repeat (nb) enc.pls(1);
    repeat (5) @(posedge ref_clk);
    axr(`EPC_OFF_POS, nf - nb);
    // the step into the reload phase lands together with the index
    for (p = 0; p < 4; p = p + 1)
    begin
      rv = $urandom;
      nf = $urandom_range(2, 0);
      axw(`EPC_OFF_RELOAD, rv);
      axr(`EPC_OFF_RELOAD, rv);
      axw(`EPC_OFF_CTRL, 32'h0);
      axw(`EPC_OFF_CTRL, 32'hd | (p << 4));
      enc.cyc(1, p[2:0]);
      repeat (nf) enc.cyc(1, 3'h4);
      repeat (5) @(posedge ref_clk);
      ex = rv + (p == 1 ? 3 : p == 3 ? 2 : p == 2 ? 1 : 0) + 4 * nf;
      axr(`EPC_OFF_POS, ex);
    end
    axw(`EPC_OFF_CTRL, 32'h0);
    axw(`EPC_OFF_CTRL, 32'h45);
    ex = 0;
    for (m = 0; m < 2; m = m + 1)
    begin
      nf = $urandom_range(3, 1);
      ex = ex + 4 * nf;
      // second pass samples on the falling pin edge, raised before moving
      if (m == 1)
      begin
        axw(`EPC_OFF_CTRL, 32'hc5);
        enc.put(4'h1);
      end
      repeat (nf) enc.cyc(1, 3'h4);
      if (m == 1)
        enc.put(4'h0);
      else
        enc.smp;
      q.push_back(ex);
      repeat (5) @(posedge ref_clk);
      axr(`EPC_OFF_STATUS, 32'h3);
      axr(`EPC_OFF_SAVE, q.pop_front());
      axr(`EPC_OFF_STATUS, 32'h1);
    end
    chk("pulses", sv_seen, 2);
    wrap_up;
  end
endmodule

// ### shared/epc_map.vh
`ifndef EPC_MAP_VH
`define EPC_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define EPC_OFF_CTRL    12'h000
`define EPC_OFF_RELOAD  12'h004
`define EPC_OFF_POS     12'h008
`define EPC_OFF_SAVE    12'h00c
`define EPC_OFF_STATUS  12'h010

// ----------------------------------------
// control fields
// ----------------------------------------
`define EPC_CTRL_ARM     0
`define EPC_CTRL_MODE_LO 1
`define EPC_CTRL_MODE_HI 2
`define EPC_CTRL_ZEN     3
`define EPC_CTRL_PH_LO   4
`define EPC_CTRL_PH_HI   5
`define EPC_CTRL_BUF     6
`define EPC_CTRL_SCPOL   7
`define EPC_CTRL_RST     8'h00

// ----------------------------------------
// decode modes
// ----------------------------------------
`define EPC_MODE_SINGLE_EDGE_DECODE 2'h0
`define EPC_MODE_DOUBLE_EDGE_DECODE 2'h1
`define EPC_MODE_QUAD_EDGE_DECODE   2'h2
`define EPC_MODE_TWO     2'h3

// ----------------------------------------
// status fields
// ----------------------------------------
`define EPC_ST_ARMED     0
`define EPC_ST_SVALID    1
`define EPC_ST_OVR       2
`define EPC_ST_A         3
`define EPC_ST_B         4
`define EPC_ST_Z         5

// ----------------------------------------
// bus answers
// ----------------------------------------
`define EPC_RESP_OKAY    2'h0
`define EPC_RESP_SLVERR  2'h2

`endif
